// File: src/otl_regs.sv
// overtemperature limit, response and overcurrent warning register bank
//
// Functional notes
// - overcurrent warning exponent fixed at minus one
// - overcurrent mantissa upper four bits stay zero
// - overcurrent default 34 A or 22 A
// - fault when sensed temperature exceeds fault limit
// - fault limit not above warning: error, alert
// - fault limit exponent zero, resets to 125
// - fault limit valid from 120 to 165
// - fault sets summary, fault bit, alert
// - fault flag held until 20 below limit
// - response bits 2..0 read as ones
// - select bit resets one; chooses ignore or shutdown
// - retry 000 latches off; 111 restarts forever
// - other retry codes rejected with error, alert
// - only retry bit 3 kept in storage
// - internal faults always shut down and retry
// - warning sets summary, warning bit, alert
// - warning flag held until 20 below limit
// - warning limit not below fault: error, alert
// - restore sets warning to max(fault-25, 100)
// - fault limit and response saved on store
// - warning limit zero exponent, 100 to 140
`timescale 1ns/1ps
module otl_regs
	import otl_pkg::*;
#(
	parameter bit HIGH_CURRENT = 1'b1,
	parameter int RAMP_CYC = RAMP_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CMD_WR,
	input wire logic CMD_RD,
	input wire logic [7:0] CMD_CODE,
	input wire logic [15:0] CMD_WDATA,
	output logic [15:0] CMD_RDATA,
	input wire logic CLEAR_FAULTS,
	input wire logic [10:0] TEMP_EXT,
	input wire logic INT_OT,
	input wire logic NV_LOAD,
	input wire logic [10:0] NV_FAULT_MANT,
	input wire logic NV_RESP_SEL,
	input wire logic NV_RETRY_BIT,
	input wire logic STORE_ALL,
	output logic NV_SAVE,
	output logic [10:0] NV_SAVE_FAULT,
	output logic NV_SAVE_SEL,
	output logic NV_SAVE_RETRY,
	output logic STAT_CML,
	output logic STAT_IVD,
	output logic STAT_TEMP,
	output logic STAT_OT_FAULT,
	output logic STAT_OT_WARN,
	output logic ALERT_N,
	output logic POWER_EN
);
	// ----------------------------------------------------------------
	// elaboration checks and derived widths
	// ----------------------------------------------------------------
	localparam int CW = (RAMP_CYC > 2) ? $clog2(RAMP_CYC) : 1;
	localparam logic [CW-1:0] RC_LAST = CW'(RAMP_CYC - 1);
	localparam logic [6:0] OCW_DEF = HIGH_CURRENT ? OCW_DEF_HI : OCW_DEF_LO;
	localparam logic [6:0] OCW_MAX = HIGH_CURRENT ? OCW_MAX_HI : OCW_MAX_LO;

	generate
		if (RAMP_CYC < 2) begin : g_bad_ramp
			$error("RAMP_CYC must be at least 2");
		end
	endgenerate

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [10:0] fault_mant_ff; // fault limit, degrees
	logic [10:0] warn_mant_ff; // warning limit, degrees
	logic [6:0] ocw_mant_ff; // overcurrent warning, half amperes
	logic fault_ignore_select_ff; // 1 shuts down, 0 keeps running
	logic retry_bit_ff; // one bit stands for the whole retry field
	logic [2:0] retry_select_field; // replicated view of retry_bit_ff
	logic [10:0] warn_restored; // warning limit derived on restore
	logic [10:0] fault_less_off; // fault limit minus offset

	assign retry_select_field = {3{retry_bit_ff}};
	assign fault_less_off = NV_FAULT_MANT - WARN_OFFSET;
	assign warn_restored = (NV_FAULT_MANT < WARN_MIN + WARN_OFFSET) ?
		WARN_MIN : fault_less_off;

	// ----------------------------------------------------------------
	// write decode and cross checks
	// ----------------------------------------------------------------
	logic [10:0] wr_mant; // mantissa field of the written word
	logic [2:0] wr_retry; // retry field of the written byte
	logic wr_fault; // write to fault limit
	logic wr_warn; // write to warning limit
	logic wr_resp; // write to response register
	logic wr_ocw; // write to overcurrent warning
	logic fault_ok; // new fault limit acceptable
	logic warn_ok; // new warning limit acceptable
	logic resp_ok; // retry code acceptable
	logic ocw_ok; // overcurrent value acceptable
	logic wr_reject; // any rejected write

	assign wr_mant = CMD_WDATA[10:0]; // exponent bits 15..11 ignored
	assign wr_retry = CMD_WDATA[RESP_RETRY_LSB+2:RESP_RETRY_LSB];
	assign wr_fault = CMD_WR && CMD_CODE == CMD_OT_FAULT;
	assign wr_warn = CMD_WR && CMD_CODE == CMD_OT_WARN;
	assign wr_resp = CMD_WR && CMD_CODE == CMD_OT_RESP;
	assign wr_ocw = CMD_WR && CMD_CODE == CMD_OC_WARN;
	// fault must sit above the warning and inside its range
	assign fault_ok = wr_mant > warn_mant_ff && wr_mant >= FAULT_MIN &&
		wr_mant <= FAULT_MAX;
	// warning must sit below the fault and inside its range
	assign warn_ok = wr_mant < fault_mant_ff && wr_mant >= WARN_MIN &&
		wr_mant <= WARN_MAX;
	assign resp_ok = wr_retry == RETRY_NONE ||
		wr_retry == RETRY_ALWAYS;
	// only the low seven bits are looked at, the rest stay zero
	assign ocw_ok = CMD_WDATA[6:0] >= OCW_MIN &&
		CMD_WDATA[6:0] <= OCW_MAX;
	assign wr_reject = (wr_fault && !fault_ok) || (wr_warn && !warn_ok) ||
		(wr_resp && !resp_ok) || (wr_ocw && !ocw_ok);

	// fault limit: reset, restore or accepted write
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fault_mant_ff <= FAULT_RST;
		end else if (NV_LOAD) begin
			fault_mant_ff <= NV_FAULT_MANT;
		end else if (wr_fault && fault_ok) begin
			fault_mant_ff <= wr_mant;
		end
	end

	// warning limit: not stored, so restore derives it from the fault
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			warn_mant_ff <= WARN_RST;
		end else if (NV_LOAD) begin
			warn_mant_ff <= warn_restored;
		end else if (wr_warn && warn_ok) begin
			warn_mant_ff <= wr_mant;
		end
	end

	// response register; a bad retry code rejects the whole byte
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fault_ignore_select_ff <= RESP_RST[RESP_SEL_BIT];
			retry_bit_ff <= RESP_RST[RESP_RETRY_LSB];
		end else if (NV_LOAD) begin
			fault_ignore_select_ff <= NV_RESP_SEL;
			retry_bit_ff <= NV_RETRY_BIT;
		end else if (wr_resp && resp_ok) begin
			fault_ignore_select_ff <= CMD_WDATA[RESP_SEL_BIT];
			retry_bit_ff <= CMD_WDATA[RESP_RETRY_LSB];
		end
	end

	// overcurrent warning: default depends on current variant
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ocw_mant_ff <= OCW_DEF;
		end else if (NV_LOAD) begin
			ocw_mant_ff <= OCW_DEF;
		end else if (wr_ocw && ocw_ok) begin
			ocw_mant_ff <= CMD_WDATA[6:0];
		end
	end

	// ----------------------------------------------------------------
	// read path, one cycle latency, unknown codes read zero
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			CMD_RDATA <= 16'h0000;
		end else if (CMD_RD) begin
			case (CMD_CODE)
				CMD_OT_FAULT: CMD_RDATA <= {5'h00, fault_mant_ff};
				CMD_OT_WARN: CMD_RDATA <= {5'h00, warn_mant_ff};
				CMD_OT_RESP: CMD_RDATA <= {8'h00, fault_ignore_select_ff,
					1'b0, retry_select_field, RESP_DELAY_CODE};
				CMD_OC_WARN: CMD_RDATA <= {OCW_EXP, 4'h0,
					ocw_mant_ff};
				default: CMD_RDATA <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// store to nonvolatile memory
	// ----------------------------------------------------------------
	// snapshot taken with the pulse so the store engine sees a stable word
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			NV_SAVE <= 1'b0;
			NV_SAVE_FAULT <= FAULT_RST;
			NV_SAVE_SEL <= RESP_RST[RESP_SEL_BIT];
			NV_SAVE_RETRY <= RESP_RST[RESP_RETRY_LSB];
		end else begin
			NV_SAVE <= STORE_ALL;
			if (STORE_ALL) begin
				NV_SAVE_FAULT <= fault_mant_ff;
				NV_SAVE_SEL <= fault_ignore_select_ff;
				NV_SAVE_RETRY <= retry_bit_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// temperature comparison
	// ----------------------------------------------------------------
	logic overtemp_fault_flag; // latched fault level
	logic overtemp_warning_level; // latched warning level

	otl_hyst_flag u_fault (
		.clk(REF_CLK),
		.rst(RST),
		.temp(TEMP_EXT),
		.limit(fault_mant_ff),
		.flag(overtemp_fault_flag)
	);

	otl_hyst_flag u_warn (
		.clk(REF_CLK),
		.rst(RST),
		.temp(TEMP_EXT),
		.limit(warn_mant_ff),
		.flag(overtemp_warning_level)
	);

	// ----------------------------------------------------------------
	// sticky status and alert
	// ----------------------------------------------------------------
	logic nxt_cml; // communication error summary
	logic nxt_ivd; // invalid data
	logic nxt_temp; // temperature summary
	logic nxt_otf; // fault status
	logic nxt_otw; // warning status

	// set wins over the clear so no event is lost
	always_comb begin
		nxt_cml = wr_reject || (STAT_CML && !CLEAR_FAULTS);
		nxt_ivd = wr_reject || (STAT_IVD && !CLEAR_FAULTS);
		nxt_otf = overtemp_fault_flag ||
			(STAT_OT_FAULT && !CLEAR_FAULTS);
		nxt_otw = overtemp_warning_level ||
			(STAT_OT_WARN && !CLEAR_FAULTS);
		nxt_temp = overtemp_fault_flag || overtemp_warning_level ||
			(STAT_TEMP && !CLEAR_FAULTS);
	end

	// alert follows the status so both move on the same edge
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			STAT_CML <= 1'b0;
			STAT_IVD <= 1'b0;
			STAT_TEMP <= 1'b0;
			STAT_OT_FAULT <= 1'b0;
			STAT_OT_WARN <= 1'b0;
			ALERT_N <= 1'b1;
		end else begin
			STAT_CML <= nxt_cml;
			STAT_IVD <= nxt_ivd;
			STAT_TEMP <= nxt_temp;
			STAT_OT_FAULT <= nxt_otf;
			STAT_OT_WARN <= nxt_otw;
			ALERT_N <= !(nxt_cml || nxt_ivd || nxt_temp || nxt_otf ||
				nxt_otw);
		end
	end

	// ----------------------------------------------------------------
	// shutdown and restart sequencer
	// ----------------------------------------------------------------
	otl_state_e state_ff; // sequencer state
	otl_state_e nxt_state; // next sequencer state
	logic fault_prev_ff; // previous external fault level
	logic int_prev_ff; // previous internal fault level
	logic ext_trip; // external fault rising edge
	logic int_trip; // internal fault rising edge
	logic trip; // shutdown request
	logic cooled; // both sources released
	logic [CW-1:0] ramp_cnt_ff; // cycles within one ramp time
	logic [2:0] ramp_num_ff; // ramp times elapsed
	logic ramp_tick; // one-cycle enable per ramp time
	logic delay_done; // seventh ramp time over

	assign ext_trip = overtemp_fault_flag && !fault_prev_ff;
	assign int_trip = INT_OT && !int_prev_ff;
	// ignore mode still flags, but only internal faults force a shutdown
	assign trip = (ext_trip && fault_ignore_select_ff) || int_trip;
	assign cooled = !overtemp_fault_flag && !INT_OT;
	assign ramp_tick = state_ff == ST_DELAY && ramp_cnt_ff == RC_LAST;
	assign delay_done = ramp_tick && ramp_num_ff == RESTART_RAMPS - 3'h1;

	// edge history of both fault sources
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fault_prev_ff <= 1'b0;
			int_prev_ff <= 1'b0;
		end else begin
			fault_prev_ff <= overtemp_fault_flag;
			int_prev_ff <= INT_OT;
		end
	end

	// next state; internal faults always take the retry path
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (trip && (int_trip || retry_bit_ff)) begin
					nxt_state = ST_COOL;
				end else if (trip) begin
					nxt_state = ST_LATCH_OFF;
				end
			end
			ST_LATCH_OFF: begin
				// output held off until software clears the fault
				if (CLEAR_FAULTS && cooled) begin
					nxt_state = ST_RUN;
				end
			end
			ST_COOL: begin
				if (cooled) begin
					nxt_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (!cooled) begin
					nxt_state = ST_COOL;
				end else if (delay_done) begin
					nxt_state = ST_RUN;
				end
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	// state and power enable move together
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_ff <= ST_RUN;
			POWER_EN <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			POWER_EN <= nxt_state == ST_RUN;
		end
	end

	// ramp time divider, counting only while a restart waits
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ramp_cnt_ff <= '0;
			ramp_num_ff <= 3'h0;
		end else if (state_ff != ST_DELAY) begin
			ramp_cnt_ff <= '0;
			ramp_num_ff <= 3'h0;
		end else if (ramp_tick) begin
			ramp_cnt_ff <= '0;
			ramp_num_ff <= ramp_num_ff + 3'h1;
		end else begin
			ramp_cnt_ff <= ramp_cnt_ff + CW'(1);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	// restore wins over a write, so a write beside it is not judged
	sequence s_fault_bad_wr;
		wr_fault && !NV_LOAD && wr_mant <= warn_mant_ff;
	endsequence

	sequence s_delay_over;
		state_ff == ST_DELAY && cooled && ramp_tick &&
			ramp_num_ff == 3'h6;
	endsequence

	fault_wr_check_a: assert property (
		s_fault_bad_wr |=> STAT_CML && STAT_IVD && !ALERT_N &&
			$stable(fault_mant_ff))
		else $error("fault limit write at or below warning not rejected");

	warn_wr_check_a: assert property (
		wr_warn && !NV_LOAD && wr_mant >= fault_mant_ff |=>
			STAT_CML && STAT_IVD && !ALERT_N && $stable(warn_mant_ff))
		else $error("warning limit write at or above fault not rejected");

	retry_code_a: assert property (
		wr_resp && !NV_LOAD && !resp_ok |=> STAT_CML && !ALERT_N &&
			$stable(retry_bit_ff) && $stable(fault_ignore_select_ff))
		else $error("illegal retry code accepted");

	fault_status_a: assert property (
		TEMP_EXT > fault_mant_ff |=> ##1 STAT_OT_FAULT && STAT_TEMP &&
			!ALERT_N)
		else $error("overtemperature fault not reported");

	warn_status_a: assert property (
		TEMP_EXT > warn_mant_ff |=> ##1 STAT_OT_WARN && STAT_TEMP &&
			!ALERT_N)
		else $error("overtemperature warning not reported");

	shutdown_resp_a: assert property (
		state_ff == ST_RUN && trip |=> !POWER_EN [*2])
		else $error("fault did not shut the output down");

	latch_off_a: assert property (
		state_ff == ST_LATCH_OFF && !CLEAR_FAULTS |=> !POWER_EN)
		else $error("latched-off output restarted without a clear");

	restart_delay_a: assert property (
		s_delay_over |=> POWER_EN && state_ff == ST_RUN)
		else $error("restart not issued after seven ramp times");

	restore_warn_a: assert property (
		NV_LOAD |=> warn_mant_ff == $past(warn_restored) &&
			warn_mant_ff >= WARN_MIN)
		else $error("warning limit not derived on restore");

	ocw_format_a: assert property (
		CMD_RD && CMD_CODE == CMD_OC_WARN |=>
			CMD_RDATA[15:7] == {OCW_EXP, 4'h0})
		else $error("overcurrent warning format wrong");

	resp_fixed_a: assert property (
		CMD_RD && CMD_CODE == CMD_OT_RESP |=>
			CMD_RDATA[2:0] == RESP_DELAY_CODE && !CMD_RDATA[6])
		else $error("response fixed bits wrong");
endmodule

// File: common/otl_pkg.sv
// constants shared by the overtemperature limit and response register bank
package otl_pkg;
	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_OC_WARN = 8'h4a;
	localparam logic [7:0] CMD_OT_FAULT = 8'h4f;
	localparam logic [7:0] CMD_OT_RESP = 8'h50;
	localparam logic [7:0] CMD_OT_WARN = 8'h51;

	// ----------------------------------------------------------------
	// threshold mantissas, one degree per step
	// ----------------------------------------------------------------
	localparam int MANT_W = 11;
	localparam logic [10:0] FAULT_RST = 11'h07d;
	localparam logic [10:0] FAULT_MIN = 11'h078;
	localparam logic [10:0] FAULT_MAX = 11'h0a5;
	localparam logic [10:0] WARN_RST = 11'h074;
	localparam logic [10:0] WARN_MIN = 11'h064;
	localparam logic [10:0] WARN_MAX = 11'h08c;
	localparam logic [10:0] WARN_OFFSET = 11'h019;
	localparam logic [10:0] HYST_DEG = 11'h014;

	// ----------------------------------------------------------------
	// overcurrent warning word: exponent -1, seven mantissa bits
	// ----------------------------------------------------------------
	localparam logic [4:0] OCW_EXP = 5'h1f;
	localparam logic [6:0] OCW_DEF_HI = 7'h44;
	localparam logic [6:0] OCW_DEF_LO = 7'h2c;
	localparam logic [6:0] OCW_MAX_HI = 7'h4f;
	localparam logic [6:0] OCW_MAX_LO = 7'h47;
	localparam logic [6:0] OCW_MIN = 7'h08;

	// ----------------------------------------------------------------
	// response register layout
	// ----------------------------------------------------------------
	localparam logic [7:0] RESP_RST = 8'hbf;
	localparam int RESP_SEL_BIT = 7;
	localparam int RESP_RETRY_LSB = 3;
	localparam logic [2:0] RESP_DELAY_CODE = 3'h7;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_ALWAYS = 3'h7;

	// ----------------------------------------------------------------
	// restart delay timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RAMP_TIME_NS = 5000000;
	localparam int RAMP_CYCLES = RAMP_TIME_NS / CLK_PERIOD_NS;
	localparam logic [2:0] RESTART_RAMPS = 3'h7;

	// restart sequencer states
	typedef enum logic [1:0] {
		ST_RUN,
		ST_LATCH_OFF,
		ST_COOL,
		ST_DELAY
	} otl_state_e;
endpackage

// File: src/otl_hyst_flag.sv
// temperature comparator with latched trip and fixed release hysteresis
`timescale 1ns/1ps
module otl_hyst_flag
	import otl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [10:0] temp,
	input wire logic [10:0] limit,
	output logic flag
);
	// ----------------------------------------------------------------
	// trip and release
	// ----------------------------------------------------------------
	logic [10:0] release_lvl; // temperature at or below which flag drops
	logic trip; // temperature above limit

	assign release_lvl = limit - HYST_DEG;
	assign trip = temp > limit;

	// set wins, so a hot sample never loses against a release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (trip) begin
			flag <= 1'b1;
		end else if (temp <= release_lvl) begin
			flag <= 1'b0;
		end
	end

	// flag must hold while temperature is within the hysteresis band
	hyst_hold_a: assert property (@(posedge clk) disable iff (rst)
		flag && temp > release_lvl |=> flag)
		else $error("latched flag dropped inside hysteresis band");
endmodule

// File: dv/otl_host.sv
// host model issuing configuration commands to the register bank
`timescale 1ns/1ps
module otl_host (
	input wire logic clk,
	input wire logic [15:0] rdata,
	output logic wr,
	output logic rd,
	output logic [7:0] code,
	output logic [15:0] wdata,
	output logic clr,
	output logic store
);
	// ------------------------------------------------------------
	// idle bus
	// ------------------------------------------------------------
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		code = 8'h00;
		wdata = 16'h0000;
		clr = 1'b0;
		store = 1'b0;
	end

	// one strobe per command; code and data flip once idle so that
	// nothing stale can pass for a real request
	task automatic cmd(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		code <= c;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		code <= ~c;
		wdata <= ~d;
	endtask

	// read answer is registered, so it is taken one edge later
	task automatic rdw(input logic [7:0] c, output logic [15:0] d);
		cmd(1'b0, c, 16'h0000);
		@(posedge clk);
		#1 d = rdata;
	endtask

	// store-all when s is set, clear-faults otherwise
	task automatic pulse(input logic s);
		@(posedge clk);
		if (s) store <= 1'b1;
		else clr <= 1'b1;
		@(posedge clk);
		store <= 1'b0;
		clr <= 1'b0;
	endtask
endmodule

// File: dv/otl_regs_tb.sv
// self-checking bench for the overtemperature register bank
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	n_fail++; $display("unexpected at %0t: got %h exp %h", $time, \
	(a), (e)); end end
module otl_regs_tb;
	// code, write word, expected read word, expected rejection
	typedef struct packed {
		logic [7:0] c;
		logic [15:0] w;
		logic [15:0] r;
		logic e;
	} otl_row_s;
	otl_row_s rows [18] = '{
		{8'h4f, 16'h0082, 16'h0082, 1'b0}, {8'h4f, 16'hf8a5, 16'h00a5, 1'b0},
		{8'h4f, 16'h00a6, 16'h00a5, 1'b1}, {8'h4f, 16'h0077, 16'h00a5, 1'b1},
		{8'h51, 16'h008c, 16'h008c, 1'b0}, {8'h51, 16'h0063, 16'h008c, 1'b1},
		{8'h51, 16'h008d, 16'h008c, 1'b1}, {8'h51, 16'h0078, 16'h0078, 1'b0},
		{8'h4f, 16'h0078, 16'h00a5, 1'b1}, {8'h4f, 16'h0082, 16'h0082, 1'b0},
		{8'h51, 16'h0082, 16'h0078, 1'b1}, {8'h50, 16'h0000, 16'h0007, 1'b0},
		{8'h50, 16'h00f8, 16'h00bf, 1'b0}, {8'h50, 16'h0090, 16'h00bf, 1'b1},
		{8'h4a, 16'h0050, 16'hf844, 1'b1}, {8'h4a, 16'h0f4f, 16'hf84f, 1'b0},
		{8'h4a, 16'h0007, 16'hf84f, 1'b1}, {8'h4a, 16'h0008, 16'hf808, 1'b0}
	};
	logic [7:0] rc [4] = '{8'h4f, 8'h50, 8'h51, 8'h4a};
	logic [15:0] rv [4] = '{16'h007d, 16'h00bf, 16'h0074, 16'hf844};
	logic REF_CLK, RST, INT_OT, NV_LOAD, NV_RESP_SEL, NV_RETRY_BIT;
	logic [10:0] TEMP_EXT, NV_FAULT_MANT, NV_SAVE_FAULT;
	logic CMD_WR, CMD_RD, CLEAR_FAULTS, STORE_ALL, NV_SAVE, NV_SAVE_SEL;
	logic [7:0] CMD_CODE;
	logic [15:0] CMD_WDATA, CMD_RDATA, rd;
	logic NV_SAVE_RETRY, STAT_CML, STAT_IVD, STAT_TEMP, STAT_OT_FAULT;
	logic STAT_OT_WARN, ALERT_N, POWER_EN;
	int n_fail = 0;
	int samples_checked = 0;

	// ------------------------------------------------------------
	// clock, stimulus at time zero, instances
	// ------------------------------------------------------------
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	// reset is up from time zero; the side inputs settle at the first edge
	initial begin
		RST = 1'b1;
	end
	otl_host u_otl_host (.clk(REF_CLK), .rdata(CMD_RDATA), .wr(CMD_WR),
		.rd(CMD_RD), .code(CMD_CODE), .wdata(CMD_WDATA),
		.clr(CLEAR_FAULTS), .store(STORE_ALL));
	// short ramp keeps the restart delay to 28 cycles
	otl_regs #(.HIGH_CURRENT(1'b1), .RAMP_CYC(4)) u_otl_regs (
		.REF_CLK(REF_CLK), .RST(RST), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
		.CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
		.CLEAR_FAULTS(CLEAR_FAULTS), .TEMP_EXT(TEMP_EXT), .INT_OT(INT_OT),
		.NV_LOAD(NV_LOAD), .NV_FAULT_MANT(NV_FAULT_MANT),
		.NV_RESP_SEL(NV_RESP_SEL), .NV_RETRY_BIT(NV_RETRY_BIT),
		.STORE_ALL(STORE_ALL), .NV_SAVE(NV_SAVE),
		.NV_SAVE_FAULT(NV_SAVE_FAULT), .NV_SAVE_SEL(NV_SAVE_SEL),
		.NV_SAVE_RETRY(NV_SAVE_RETRY), .STAT_CML(STAT_CML),
		.STAT_IVD(STAT_IVD), .STAT_TEMP(STAT_TEMP),
		.STAT_OT_FAULT(STAT_OT_FAULT), .STAT_OT_WARN(STAT_OT_WARN),
		.ALERT_N(ALERT_N), .POWER_EN(POWER_EN));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic temp(input logic [10:0] v, input int n);
		@(posedge REF_CLK);
		TEMP_EXT <= v;
		wt(n);
	endtask
	// every reset also returns the side inputs to their idle levels
	task automatic do_reset;
		@(posedge REF_CLK);
		RST <= 1'b1;
		INT_OT <= 1'b0;
		NV_LOAD <= 1'b0;
		NV_RESP_SEL <= 1'b1;
		NV_RETRY_BIT <= 1'b1;
		NV_FAULT_MANT <= 11'h07d;
		TEMP_EXT <= 11'h019;
		repeat (6) @(posedge REF_CLK);
		RST <= 1'b0;
		#1;
	endtask
	// restore, then expect fault, warning and response words
	task automatic nv(input logic [10:0] m, input logic s, input logic r,
		input logic [15:0] ew, input logic [15:0] ep);
		@(posedge REF_CLK);
		NV_FAULT_MANT <= m;
		NV_RESP_SEL <= s;
		NV_RETRY_BIT <= r;
		NV_LOAD <= 1'b1;
		@(posedge REF_CLK);
		NV_LOAD <= 1'b0;
		u_otl_host.rdw(8'h4f, rd);
		`CHK(rd, {5'h00, m})
		u_otl_host.rdw(8'h51, rd);
		`CHK(rd, ew)
		u_otl_host.rdw(8'h50, rd);
		`CHK(rd, ep)
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog: the sequence needs about 430 cycles
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge REF_CLK);
		n_fail++;
		final_report();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		// table: write, check status, read back
		foreach (rows[i]) begin
			u_otl_host.pulse(1'b0);
			u_otl_host.cmd(1'b1, rows[i].c, rows[i].w);
			wt(1);
			`CHK(STAT_CML, rows[i].e)
			`CHK(STAT_IVD, rows[i].e)
			`CHK(ALERT_N, !rows[i].e)
			u_otl_host.rdw(rows[i].c, rd);
			`CHK(rd, rows[i].r)
		end
		// second reset in mid-run brings every default back
		do_reset();
		`CHK({STAT_CML, STAT_TEMP, ALERT_N, POWER_EN}, 4'h3)
		foreach (rc[i]) begin
			u_otl_host.rdw(rc[i], rd);
			`CHK(rd, rv[i])
		end
		// warning, then exact fault boundary, then fault
		temp(11'h075, 3);
		`CHK({STAT_OT_WARN, STAT_TEMP, ALERT_N}, 3'h6)
		temp(11'h07d, 3);
		`CHK(STAT_OT_FAULT, 1'b0)
		temp(11'h07e, 4);
		`CHK({STAT_OT_FAULT, POWER_EN, ALERT_N}, 3'h4)
		// 19 below the limit: still latched, stays off
		temp(11'h06a, 40);
		u_otl_host.pulse(1'b0);
		#1 `CHK({STAT_OT_FAULT, POWER_EN}, 2'h2)
		// 20 below: released, restart after seven ramps
		temp(11'h069, 22);
		`CHK(POWER_EN, 1'b0)
		wt(18);
		`CHK(POWER_EN, 1'b1)
		u_otl_host.pulse(1'b0);
		#1 `CHK({STAT_OT_FAULT, STAT_OT_WARN}, 2'h1)
		temp(11'h061, 3);
		u_otl_host.pulse(1'b0);
		#1 `CHK(STAT_OT_WARN, 1'b1)
		temp(11'h060, 3);
		u_otl_host.pulse(1'b0);
		#1 `CHK({STAT_OT_WARN, ALERT_N}, 2'h1)
		// retry 000: latched off until cleared
		u_otl_host.cmd(1'b1, 8'h50, 16'h0080);
		temp(11'h07e, 4);
		`CHK(POWER_EN, 1'b0)
		temp(11'h019, 50);
		`CHK(POWER_EN, 1'b0)
		u_otl_host.pulse(1'b0);
		wt(2);
		`CHK(POWER_EN, 1'b1)
		// ignore mode: external fault only flagged, internal still trips
		u_otl_host.cmd(1'b1, 8'h50, 16'h0038);
		temp(11'h07e, 4);
		`CHK({STAT_OT_FAULT, POWER_EN, ALERT_N}, 3'h6)
		temp(11'h019, 3);
		@(posedge REF_CLK);
		INT_OT <= 1'b1;
		wt(4);
		`CHK(POWER_EN, 1'b0)
		@(posedge REF_CLK);
		INT_OT <= 1'b0;
		wt(40);
		`CHK(POWER_EN, 1'b1)
		// restore derives the warning limit and widens the retry bit
		nv(11'h096, 1'b0, 1'b1, 16'h007d, 16'h003f);
		nv(11'h078, 1'b1, 1'b0, 16'h0064, 16'h0087);
		u_otl_host.pulse(1'b1);
		#1 `CHK({NV_SAVE, NV_SAVE_FAULT, NV_SAVE_SEL, NV_SAVE_RETRY},
			14'h21e2)
		wt(1);
		`CHK(NV_SAVE, 1'b0)
		final_report();
	end
endmodule
